// ---- rtl/rtcrt_consts.svh ----
`ifndef RTCRT_CONSTS_SVH
`define RTCRT_CONSTS_SVH

// Timebase divider: 32768 oscillator periods per second.
`define RTCRT_DIV_TOP     17'h07FFF
`define RTCRT_DIV_HALF    17'h04000
`define RTCRT_DIV_ZERO    17'h00000

// Adjustment interval lengths in seconds.
`define RTCRT_PER_COARSE  6'h14
`define RTCRT_PER_FINE    6'h3C

// Correction setting field positions.
`define RTCRT_RES_BIT     0
`define RTCRT_STEP_MSB    7
`define RTCRT_STEP_LSB    1
`define RTCRT_TRIM_RESET  8'h00

// Serial port: device code is arbitrary, command selects the trim register.
`define RTCRT_DEV_CODE    4'h6
`define RTCRT_CMD_TRIM    3'h4
`define RTCRT_BITS_BYTE   4'h8
`define RTCRT_BUF_DEPTH   2'h2

`endif

// ---- rtl/rtcrt_pkg.sv ----
package rtcrt_pkg;

    typedef struct packed {
        logic osc;
        logic scl;
        logic sda;
    } rtcrt_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK,
        ST_IGNORE
    } rtcrt_state_t;

endpackage

// ---- rtl/rtcrt_top.sv ----
`timescale 1ns/1ps
`include "rtcrt_consts.svh"

module rtcrt_top
    import rtcrt_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic crystal_in,
    input  wire logic serial_clock,
    input  wire logic serial_data_in,
    output logic      serial_data_out,
    output logic      serial_data_oe,
    output logic      constant_crystal_output,
    output logic      second_interrupt_output
);

    rtcrt_pins_t         pins_m;
    rtcrt_pins_t         pins_s;
    rtcrt_pins_t         pins_p;
    logic                osc_rise;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_cond;
    logic                stop_cond;
    logic signed [16:0]  div;
    logic        [5:0]   sec_cnt;
    logic        [5:0]   period;
    logic                last_sec;
    logic                sec_wrap;
    logic                interval_wrap;
    logic        [7:0]   rate_trim_setting;
    logic        [7:0]   active_setting;
    logic        [6:0]   step;
    logic signed [16:0]  trim_start;
    rtcrt_state_t        state;
    logic        [3:0]   bit_cnt;
    logic        [7:0]   shift;
    logic                wrote_once;
    logic                master_ack;
    logic        [7:0]   buf_data [2];
    logic                wr_ptr;
    logic                rd_ptr;
    logic        [1:0]   buf_cnt;
    logic                push;
    logic                push_ready;
    logic                pop;

    always_ff @(posedge clock or negedge rst_n) begin
        // Idle bus levels at reset, so that no false edge follows release.
        if (!rst_n) begin
            pins_m <= '{osc: 1'b0, scl: 1'b1, sda: 1'b1};
            pins_s <= '{osc: 1'b0, scl: 1'b1, sda: 1'b1};
            pins_p <= '{osc: 1'b0, scl: 1'b1, sda: 1'b1};
        end else begin
            pins_m <= '{osc: crystal_in, scl: serial_clock,
                        sda: serial_data_in};
            pins_s <= pins_m;
            pins_p <= pins_s;
        end
    end

    assign osc_rise   = pins_s.osc & ~pins_p.osc;
    assign scl_rise   = pins_s.scl & ~pins_p.scl;
    assign scl_fall   = ~pins_s.scl & pins_p.scl;
    // A data edge with the clock held high is always a bus condition.
    assign start_cond = pins_s.scl & pins_p.scl & pins_p.sda & ~pins_s.sda;
    assign stop_cond  = pins_s.scl & pins_p.scl & ~pins_p.sda & pins_s.sda;

    // The crystal is only forwarded, never gated by the trim logic.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            constant_crystal_output <= 1'b0;
        end else begin
            constant_crystal_output <= pins_s.osc;
        end
    end

    genvar k;
    generate
        for (k = 0; k < 7; k++) begin : g_step
            assign step[k] = active_setting[`RTCRT_STEP_MSB - k];
        end
    endgenerate

    // Each step moves the second boundary by two oscillator periods.
    assign trim_start = {{9{step[6]}}, step, 1'b0};
    assign period     = active_setting[`RTCRT_RES_BIT] ?
                        `RTCRT_PER_FINE : `RTCRT_PER_COARSE;
    assign last_sec      = sec_cnt == period - 6'h01;
    assign sec_wrap      = osc_rise && div == $signed(`RTCRT_DIV_TOP);
    assign interval_wrap = sec_wrap && last_sec;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div <= `RTCRT_DIV_ZERO;
        end else if (sec_wrap) begin
            div <= last_sec ? trim_start : `RTCRT_DIV_ZERO;
        end else if (osc_rise) begin
            div <= div + 17'sh00001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt <= 6'h00;
        end else if (interval_wrap) begin
            sec_cnt <= 6'h00;
        end else if (sec_wrap) begin
            sec_cnt <= sec_cnt + 6'h01;
        end
    end

    // The setting in use is only replaced at an interval boundary.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            active_setting <= `RTCRT_TRIM_RESET;
        end else if (interval_wrap) begin
            active_setting <= rate_trim_setting;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            second_interrupt_output <= 1'b0;
        end else begin
            second_interrupt_output <= div < $signed(`RTCRT_DIV_HALF);
        end
    end

    // Two-entry buffer between the serial receiver and the trim register.
    // A full buffer makes the receiver refuse the byte with no acknowledge.
    assign push_ready = buf_cnt != `RTCRT_BUF_DEPTH;
    assign push = scl_fall && state == ST_WDATA && bit_cnt == `RTCRT_BITS_BYTE
                  && !wrote_once && push_ready;
    assign pop  = buf_cnt != 2'h0 && !osc_rise;

    always_ff @(posedge clock) begin
        if (push) begin
            buf_data[wr_ptr] <= shift;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr  <= 1'b0;
            rd_ptr  <= 1'b0;
            buf_cnt <= 2'h0;
        end else begin
            wr_ptr  <= wr_ptr ^ push;
            rd_ptr  <= rd_ptr ^ pop;
            buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rate_trim_setting <= `RTCRT_TRIM_RESET;
        end else if (pop) begin
            rate_trim_setting <= buf_data[rd_ptr];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            wrote_once <= 1'b0;
            master_ack <= 1'b0;
        end else if (stop_cond) begin
            state <= ST_IDLE;
        end else if (start_cond) begin
            state      <= ST_ADDR;
            bit_cnt    <= 4'h0;
            wrote_once <= 1'b0;
        end else if (scl_rise) begin
            unique case (state)
                ST_ADDR, ST_WDATA: begin
                    shift   <= {shift[6:0], pins_s.sda};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                ST_RACK: begin
                    master_ack <= ~pins_s.sda;
                end
                ST_RDATA: begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
                ST_IDLE, ST_ADDR_ACK, ST_WACK, ST_IGNORE: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state)
                ST_ADDR: begin
                    if (bit_cnt == `RTCRT_BITS_BYTE) begin
                        if (shift[7:4] == `RTCRT_DEV_CODE
                            && shift[3:1] == `RTCRT_CMD_TRIM) begin
                            state <= ST_ADDR_ACK;
                        end else begin
                            state <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    bit_cnt <= 4'h0;
                    if (shift[0]) begin
                        state <= ST_RDATA;
                        shift <= rate_trim_setting;
                    end else begin
                        state <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (bit_cnt == `RTCRT_BITS_BYTE) begin
                        state <= push ? ST_WACK : ST_IGNORE;
                    end
                end
                ST_WACK: begin
                    state      <= ST_WDATA;
                    bit_cnt    <= 4'h0;
                    wrote_once <= 1'b1;
                end
                ST_RDATA: begin
                    if (bit_cnt == `RTCRT_BITS_BYTE) begin
                        state <= ST_RACK;
                    end else begin
                        shift <= {shift[6:0], 1'b0};
                    end
                end
                ST_RACK: begin
                    bit_cnt <= 4'h0;
                    if (master_ack) begin
                        state <= ST_RDATA;
                        shift <= rate_trim_setting;
                    end else begin
                        state <= ST_IGNORE;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                end
            endcase
        end
    end

    // Open drain: the line is pulled low when the enable is high.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_out <= 1'b0;
        end else begin
            serial_data_out <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_oe <= 1'b0;
        end else begin
            unique case (state)
                ST_ADDR_ACK, ST_WACK: serial_data_oe <= 1'b1;
                // The last bit stands through its high phase until it falls.
                ST_RDATA: serial_data_oe <= !shift[7];
                ST_IDLE, ST_ADDR, ST_WDATA, ST_RACK,
                ST_IGNORE: serial_data_oe <= 1'b0;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    start_enters_addr_a: assert property (
        start_cond && !stop_cond |=> state == ST_ADDR)
        else $error("start condition did not begin an access");
    stop_to_idle_a: assert property (
        stop_cond |=> state == ST_IDLE ##1 !serial_data_oe)
        else $error("stop condition did not return to standby");
    crystal_untouched_a: assert property (
        constant_crystal_output == $past(pins_s.osc))
        else $error("crystal output altered");
    ignore_released_a: assert property (
        state == ST_IGNORE |=> !serial_data_oe)
        else $error("line driven while ignoring");
    interval_length_a: assert property (
        sec_cnt < period)
        else $error("second count beyond interval");
    trim_apply_a: assert property (
        sec_wrap && last_sec |=> div == $past(trim_start))
        else $error("trim step not loaded at interval end");
    plain_second_a: assert property (
        sec_wrap && !last_sec |=> div == $signed(`RTCRT_DIV_ZERO))
        else $error("uncorrected second was adjusted");
    interval_hold_a: assert property (
        !interval_wrap |=> $stable(active_setting))
        else $error("setting changed inside interval");
    write_ack_a: assert property (
        push |=> state == ST_WACK ##1 serial_data_oe)
        else $error("written byte not acknowledged");
    read_msb_a: assert property (
        scl_fall && state == ST_ADDR_ACK && shift[0] && !start_cond
        && !stop_cond
        |=> ##2 serial_data_oe == !$past(rate_trim_setting[7], 3))
        else $error("read byte not started with its top bit");

    write_seen_c: cover property (state == ST_WACK);
    read_seen_c: cover property (state == ST_RACK && master_ack);
    trim_seen_c: cover property (interval_wrap && step != 7'h00);
    ignored_c: cover property (state == ST_IGNORE);

endmodule

// ---- test/rtcrt_master.sv ----
`timescale 1ns/1ps
// Bus master on the far side of the serial port. SDA has a pull-up; SCL is driven directly.
module rtcrt_master (
    input  wire logic clock,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One bit: data moves mid-low, the line is sampled mid-high.
    task automatic bit_xfer(input logic b, output logic s);
        scl <= 1'b0;
        wait_clk(8);
        sda_low <= ~b;
        wait_clk(8);
        scl <= 1'b1;
        wait_clk(8);
        s = sda_wire;
        wait_clk(7);
    endtask

    // Eight bits MSB first, then the ninth bit driven with ack_in.
    task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
                             output logic [7:0] q, output logic ack_seen);
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], q[i]);
        bit_xfer(ack_in, ack_seen);
    endtask

    task automatic start_cond();
        scl <= 1'b0;
        wait_clk(8);
        sda_low <= 1'b0;
        wait_clk(8);
        scl <= 1'b1;
        wait_clk(8);
        sda_low <= 1'b1;
        wait_clk(8);
    endtask

    task automatic stop_cond();
        scl <= 1'b0;
        wait_clk(8);
        sda_low <= 1'b1;
        wait_clk(8);
        scl <= 1'b1;
        wait_clk(8);
        sda_low <= 1'b0;
        wait_clk(8);
    endtask

    // Frees a port stuck driving SDA low.
    task automatic recover();
        logic s;
        start_cond();
        repeat (63) bit_xfer(1'b1, s);
        stop_cond();
    endtask
endmodule

// ---- test/rtcrt_top_test.sv ----
`timescale 1ns/1ps
`include "rtcrt_consts.svh"
module rtcrt_top_test;
    logic       clock;
    logic       rst_n;
    logic       crystal_in;
    logic       scl;
    logic       sda_low;
    logic       sda_wire;
    logic       dout;
    logic       doe;
    logic       cco;
    logic       sio;
    logic       xchk;
    logic [4:0] osc_cnt;
    logic [7:0] q;
    logic [7:0] v;
    logic       a;
    logic       s;
    int         bad_count;
    int         samples_checked;

    assign sda_wire = ~(sda_low | (doe & ~dout));

    rtcrt_top DUT (
        .clock                   (clock),
        .rst_n                   (rst_n),
        .crystal_in              (crystal_in),
        .serial_clock            (scl),
        .serial_data_in          (sda_wire),
        .serial_data_out         (dout),
        .serial_data_oe          (doe),
        .constant_crystal_output (cco),
        .second_interrupt_output (sio)
    );

    rtcrt_master M (
        .clock    (clock),
        .sda_wire (sda_wire),
        .scl      (scl),
        .sda_low  (sda_low)
    );

    always #2 clock = ~clock;

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [7:0] addr_byte(input logic [3:0] code,
                                             input logic rw);
        return {code, `RTCRT_CMD_TRIM, rw};
    endfunction

    task automatic write_trim(input logic [3:0] code, input logic [7:0] d);
        logic [7:0] exp;
        exp = (code == `RTCRT_DEV_CODE) ? 8'h00 : 8'h01;
        M.start_cond();
        M.byte_xfer(addr_byte(code, 1'b0), 1'b1, q, a);
        check("address ack", {7'h00, a}, exp);
        M.byte_xfer(d, 1'b1, q, a);
        check("data ack", {7'h00, a}, exp);
        M.stop_cond();
    endtask

    task automatic read_trim(input logic [7:0] exp, input int n);
        M.start_cond();
        M.byte_xfer(addr_byte(`RTCRT_DEV_CODE, 1'b1), 1'b1, q, a);
        check("read address ack", {7'h00, a}, 8'h00);
        for (int i = 0; i < n; i++) begin
            M.byte_xfer(8'hFF, (i == n - 1), q, a);
            check("read data", q, exp);
        end
        M.stop_cond();
    endtask

    // Crystal with random half periods; its copy must follow it.
    always @(posedge clock) begin
        if (osc_cnt == 5'h00) begin
            crystal_in <= ~crystal_in;
            osc_cnt <= 5'(6 + $urandom % 4);
        end else begin
            osc_cnt <= osc_cnt - 5'h01;
        end
        if (xchk && osc_cnt == 5'h01) begin
            check("crystal copy", {7'h00, cco}, {7'h00, crystal_in});
            check("second phase", {7'h00, sio}, 8'h01);
            check("drive value", {7'h00, dout}, 8'h00);
        end
    end

    initial begin
        #300000;
        bad_count++;
        conclude();
    end

    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        crystal_in = 1'b0;
        osc_cnt = 5'h00;
        xchk = 1'b0;
        void'($urandom(98638));
        repeat (20) @(posedge clock);
        check("oe in reset", {7'h00, doe}, 8'h00);
        check("second in reset", {7'h00, sio}, 8'h00);
        rst_n <= 1'b1;
        repeat (10) @(posedge clock);
        xchk <= 1'b1;
        read_trim(`RTCRT_TRIM_RESET, 1);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h66 : (i == 1) ? 8'hFF : 8'($urandom);
            write_trim(`RTCRT_DEV_CODE, v);
            read_trim(v, 2);
        end
        // A foreign device code leaves the setting alone.
        write_trim(4'h5, 8'h11);
        read_trim(v, 1);
        // A second data byte in one access is refused.
        M.start_cond();
        M.byte_xfer(addr_byte(`RTCRT_DEV_CODE, 1'b0), 1'b1, q, a);
        M.byte_xfer(8'h3C, 1'b1, q, a);
        M.byte_xfer(8'hC3, 1'b1, q, a);
        check("second byte ack", {7'h00, a}, 8'h01);
        M.stop_cond();
        read_trim(8'h3C, 1);
        // A stop in mid-byte abandons the write.
        M.start_cond();
        M.byte_xfer(addr_byte(`RTCRT_DEV_CODE, 1'b0), 1'b1, q, a);
        repeat (4) M.bit_xfer(1'b0, s);
        M.stop_cond();
        read_trim(8'h3C, 1);
        // Port stuck mid-read driving low, then recovered.
        write_trim(`RTCRT_DEV_CODE, 8'h00);
        M.start_cond();
        M.byte_xfer(addr_byte(`RTCRT_DEV_CODE, 1'b1), 1'b1, q, a);
        M.bit_xfer(1'b1, s);
        check("stuck bit", {7'h00, s}, 8'h00);
        M.recover();
        write_trim(`RTCRT_DEV_CODE, 8'h5A);
        read_trim(8'h5A, 1);
        conclude();
    end
endmodule
